// ===== rtl/sdi12_port.sv
// one sdi-12 port: recorder, sensor role, transparent and monitor use
// assumes synchronous inputs; the wire is resolved from sdi_out/sdi_oe
//
// Overview of operation
// R1 - characters run at 1200 baud on the data wire
// R2 - frames are 7 data bits, even parity, one stop, inverted line
// R3 - partner terminal is locked from counting, timing and trigger use
// R4 - transparent forwards operator chars and full replies, records none
// R5 - transparent waits until a running recorder sequence has ended
// R6 - transparent opens only while access protection is unlocked
// R7 - monitor shows traffic passively with seconds timeout and ascii option
// R8 - address is one char from 0-9, a-z or A-Z
// R9 - the ? address is honoured only in the address query
// R10 - body is one uppercase letter plus an optional C and an optional digit qualifier
// R11 - every command ends with an exclamation mark
// R12 - each addressed command is answered, ending in CR then LF
// R13 - one measure request sends aM!, waits, then sends aD0!
// R14 - commands are retried when the probe answers badly or not at all
// R15 - sensor role answers M, MC, C, CC, R, RC, V, query and I
// R16 - sensor role holds one address and ignores all others
// R17 - every port keeps its own independent sensor address
// R18 - all probes wake on a command, only the addressed one replies
// R19 - after reset no address, sequence or session is active
// R20 - missing response reports a no-response result instead of stalling
`timescale 1ns/10ps
`default_nettype none

module sdi12_port #(
	parameter int unsigned BIT_CYC  = sdi_pkg::BIT_CYCLES,
	parameter int unsigned SEC_CYC  = sdi_pkg::SEC_CYCLES,
	parameter int unsigned RESP_CYC = sdi_pkg::RESP_CYCLES
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	// sdi-12 data wire
	input  wire logic             sdi_in,
	output logic                  sdi_out,
	output logic                  sdi_oe,
	// port setup
	input  wire sdi_pkg::role_e   role,
	input  wire logic             unlocked,
	input  wire logic [6:0]       sensor_addr,
	output logic                  partner_locked,
	// recorder requests and results
	input  wire sdi_pkg::rec_req_s rec_req,
	output logic                  rec_busy,
	output sdi_pkg::char_s        rec_data,
	output sdi_pkg::rec_res_s     rec_result,
	// sensor role commands and replies
	output sdi_pkg::scmd_s        sensor_cmd,
	input  wire sdi_pkg::reply_s  reply_in,
	output logic                  reply_ready,
	// operator terminal
	input  wire sdi_pkg::char_s   term_in,
	output logic                  term_ready,
	output sdi_pkg::char_s        term_out,
	output logic                  sess_open,
	input  wire logic [7:0]       mon_timeout_s,
	input  wire logic             mon_ascii,
	output logic                  mon_open
);
	import sdi_pkg::*;

	localparam logic [BAUD_W-1:0] BIT_LAST = BAUD_W'(BIT_CYC - 1);
	localparam logic [BAUD_W-1:0] BIT_MID = BAUD_W'(BIT_CYC / 2 - 1);
	localparam logic [TMR_W-1:0] SEC_LAST = TMR_W'(SEC_CYC - 1);
	localparam logic [TMR_W-1:0] RESP_LAST = TMR_W'(RESP_CYC - 1);

	state_e                  state;
	logic                    tx_go;
	logic                    tx_busy;
	logic                    tx_free;
	logic [6:0]              tx_char;
	logic [9:0]              tx_sh;
	logic [3:0]              tx_cnt;
	logic [BAUD_W-1:0]       tx_baud;
	logic                    rx_act;
	logic                    rx_valid;
	logic [7:0]              rx_sh;
	logic [6:0]              rx_char;
	logic [3:0]              rx_cnt;
	logic [BAUD_W-1:0]       rx_baud;
	logic [6:0]              addr;
	logic                    phase_d;
	logic                    bad;
	logic                    query;
	logic                    resp_fail;
	logic [1:0]              retry;
	logic [2:0]              idx;
	logic [2:0]              cmd_len;
	logic [6:0]              cmd_char;
	logic [9:0]              ttt;
	logic [TMR_W-1:0]        tmr;
	logic [3:0][6:0]         cbuf;
	logic [2:0]              ccnt;
	logic                    parse_hit;
	scmd_s                   parse_cmd;
	logic [7:0]              mon_left;
	logic [TMR_W-1:0]        mon_tmr;
	logic                    mon_spent;

	////////////////////////////////////////////////////////////////////////
	// command decode for sensor role
	function automatic scmd_s decode(input logic [3:0][6:0] b,
		input logic [2:0] n, input logic [6:0] own);
		scmd_s      r;
		logic       crc;
		logic [6:0] q;
		logic [2:0] full;
		r = '0;
		crc = (n >= 3'h3) && (b[2] == CH_C);
		q = crc ? b[3] : b[2];
		full = crc ? 3'h4 : 3'h3;
		if (b[0] == CH_QUERY && n == 3'h1) begin
			r.kind = SK_QUERY; // R9
		end else if (b[0] == own && n >= 3'h2 && n <= full &&
			(n < full || is_digit(q))) begin // R10 R16
			case (b[1]) // R15
				CH_M: r.kind = crc ? SK_MC : SK_M;
				CH_C: r.kind = crc ? SK_CC : SK_C;
				CH_R: r.kind = crc ? SK_RC : SK_R;
				CH_V: r.kind = (n == 3'h2) ? SK_V : SK_NONE;
				CH_I: r.kind = (n == 3'h2) ? SK_I : SK_NONE;
				default: r.kind = SK_NONE;
			endcase
		end
		r.valid = (r.kind != SK_NONE);
		r.qual = (n == full) ? q : CH_ZERO;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// helpers
	assign tx_free = !tx_busy && !tx_go;
	assign rx_char = rx_sh[6:0];

	// failed reply: wrong address at end of line, or silence
	assign resp_fail = rx_valid ? (rx_char == CH_LF && bad) :
		(tmr == RESP_LAST);

	// recorder command text, aM! or aD0!
	always_comb begin
		cmd_len = phase_d ? 3'h4 : 3'h3;
		case (idx)
			3'h0: cmd_char = addr;
			3'h1: cmd_char = phase_d ? CH_D : CH_M; // R13
			3'h2: cmd_char = phase_d ? CH_ZERO : CH_EXCL;
			default: cmd_char = CH_EXCL; // R11
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// character transmitter
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tx_busy <= 1'b0;
			tx_sh <= '0;
			tx_cnt <= '0;
			tx_baud <= '0;
			sdi_out <= 1'b0;
			sdi_oe <= 1'b0;
		end else if (tx_go) begin
			tx_busy <= 1'b1;
			tx_sh <= {1'b1, ^tx_char, tx_char, 1'b0}; // R2
			tx_cnt <= '0;
			tx_baud <= '0;
		end else if (tx_busy) begin
			sdi_oe <= 1'b1;
			sdi_out <= ~tx_sh[0]; // inverted line
			if (tx_baud == BIT_LAST) begin // R1
				tx_baud <= '0;
				tx_sh <= {1'b1, tx_sh[9:1]};
				tx_cnt <= tx_cnt + 4'h1;
				if (tx_cnt == FRAME_BITS - 4'h1)
					tx_busy <= 1'b0;
			end else begin
				tx_baud <= tx_baud + 1'b1;
			end
		end else begin
			sdi_oe <= 1'b0;
			sdi_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// character receiver, deaf while we drive the wire
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rx_act <= 1'b0;
			rx_valid <= 1'b0;
			rx_sh <= '0;
			rx_cnt <= '0;
			rx_baud <= '0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_act) begin
				if (!tx_busy && !sdi_oe && sdi_in) begin
					rx_act <= 1'b1;
					rx_baud <= '0;
					rx_cnt <= '0;
				end
			end else if (rx_baud == ((rx_cnt == 4'h0) ? BIT_MID :
				BIT_LAST)) begin // R1
				rx_baud <= '0;
				rx_cnt <= rx_cnt + 4'h1;
				if (rx_cnt == 4'h0) begin
					if (!sdi_in)
						rx_act <= 1'b0; // false start
				end else if (rx_cnt == FRAME_BITS - 4'h1) begin
					rx_act <= 1'b0;
					rx_valid <= !sdi_in && !(^rx_sh); // R2
				end else begin
					rx_sh <= {~sdi_in, rx_sh[7:1]};
				end
			end else begin
				rx_baud <= rx_baud + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sensor role command collector
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cbuf <= '0;
			ccnt <= '0;
			parse_hit <= 1'b0;
			parse_cmd <= '0;
		end else begin
			parse_hit <= 1'b0;
			if (role != ROLE_SENSOR || state != ST_IDLE) begin
				ccnt <= '0;
			end else if (rx_valid) begin
				if (rx_char == CH_EXCL) begin // R11
					parse_cmd <= decode(cbuf, ccnt, sensor_addr); // R17
					parse_hit <= is_addr(sensor_addr); // R8
					ccnt <= '0;
				end else if (ccnt != 3'h5) begin
					if (ccnt < 3'h4)
						cbuf[ccnt[1:0]] <= rx_char;
					ccnt <= ccnt + 3'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: recorder, sensor replies, transparent forwarding
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE; // R19
			tx_go <= 1'b0;
			tx_char <= '0;
			addr <= '0;
			phase_d <= 1'b0;
			bad <= 1'b0;
			query <= 1'b0;
			retry <= '0;
			idx <= '0;
			ttt <= '0;
			tmr <= '0;
			term_ready <= 1'b0;
			reply_ready <= 1'b0;
			rec_data <= '0;
			rec_result <= '0;
			sensor_cmd <= '0;
		end else begin
			tx_go <= 1'b0;
			term_ready <= 1'b0;
			reply_ready <= 1'b0;
			rec_data.valid <= 1'b0;
			rec_result <= '0;
			sensor_cmd.valid <= 1'b0;
			case (state)
				ST_IDLE: begin
					tmr <= '0;
					if (role == ROLE_RECORDER && rec_req.start &&
						is_addr(rec_req.addr)) begin // R8 R13
						addr <= rec_req.addr;
						phase_d <= 1'b0;
						retry <= '0;
						idx <= '0;
						state <= ST_CMD;
					end else if (term_ready && term_in.valid) begin
						tx_go <= 1'b1; // R4
						tx_char <= term_in.data[6:0];
					end else if (parse_hit && parse_cmd.valid) begin
						sensor_cmd <= parse_cmd; // R15
						addr <= sensor_addr;
						query <= (parse_cmd.kind == SK_QUERY);
						idx <= '0;
						state <= ST_REPLY;
					end else begin
						term_ready <= sess_open && tx_free && unlocked &&
							(role == ROLE_TRANSPARENT); // R4 R6
					end
				end
				ST_CMD: begin
					if (tx_free) begin
						if (idx == cmd_len) begin
							state <= ST_RESP;
							tmr <= '0;
							idx <= '0;
							bad <= 1'b0;
							if (!phase_d)
								ttt <= '0;
						end else begin
							tx_go <= 1'b1; // R13
							tx_char <= cmd_char;
							idx <= idx + 3'h1;
						end
					end
				end
				ST_RESP: begin
					tmr <= tmr + 1'b1;
					if (resp_fail) begin
						tmr <= '0;
						idx <= '0;
						if (retry == RETRIES) begin
							rec_result <= '{done: 1'b1, no_resp: 1'b1}; // R20
							state <= ST_IDLE;
						end else begin
							retry <= retry + 2'h1; // R14
							state <= ST_CMD;
						end
					end else if (rx_valid) begin
						tmr <= '0;
						if (idx != 3'h7)
							idx <= idx + 3'h1;
						if (idx == 3'h0 && rx_char != addr)
							bad <= 1'b1; // R18
						if (!phase_d && idx >= 3'h1 && idx <= 3'h3 &&
							is_digit(rx_char))
							ttt <= 10'(ttt * 10'h00A +
								{3'h0, rx_char - CH_ZERO});
						if (phase_d && idx != 3'h0 && rx_char != CH_CR &&
							rx_char != CH_LF)
							rec_data <= '{valid: 1'b1,
								data: {1'b0, rx_char}};
						if (rx_char == CH_LF) begin // R12
							if (phase_d) begin
								rec_result <= '{done: 1'b1, no_resp: 1'b0};
								state <= ST_IDLE;
							end else begin
								state <= ST_MWAIT;
							end
						end
					end
				end
				ST_MWAIT: begin
					// announced seconds, cut short by a service request
					if (ttt == '0 || (rx_valid && rx_char == CH_LF)) begin
						phase_d <= 1'b1; // R13
						retry <= '0;
						idx <= '0;
						tmr <= '0;
						state <= ST_CMD;
					end else if (tmr == SEC_LAST) begin
						tmr <= '0;
						ttt <= ttt - 10'h001;
					end else begin
						tmr <= tmr + 1'b1;
					end
				end
				ST_REPLY: begin
					case (idx)
						3'h0: begin
							if (tx_free) begin
								tx_go <= 1'b1;
								tx_char <= addr; // R12
								idx <= query ? 3'h2 : 3'h1;
								tmr <= '0;
							end
						end
						3'h1: begin
							tmr <= tmr + 1'b1;
							if (reply_ready && reply_in.valid) begin
								tx_go <= 1'b1;
								tx_char <= reply_in.data;
								tmr <= '0;
								if (reply_in.last)
									idx <= 3'h2;
							end else if (tmr == RESP_LAST) begin
								idx <= 3'h2; // close a silent reply
							end else begin
								reply_ready <= tx_free;
							end
						end
						3'h2: begin
							if (tx_free) begin
								tx_go <= 1'b1;
								tx_char <= CH_CR; // R12
								idx <= 3'h3;
							end
						end
						3'h3: begin
							if (tx_free) begin
								tx_go <= 1'b1;
								tx_char <= CH_LF; // R12
								idx <= 3'h4;
							end
						end
						default: begin
							if (tx_free)
								state <= ST_IDLE;
						end
					endcase
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// recorder busy flag and partner terminal lock
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rec_busy <= 1'b0;
			partner_locked <= 1'b0;
		end else begin
			rec_busy <= (state == ST_CMD) || (state == ST_RESP) ||
				(state == ST_MWAIT);
			partner_locked <= (role != ROLE_IDLE); // R3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transparent session gate
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sess_open <= 1'b0; // R19
		end else begin
			sess_open <= (role == ROLE_TRANSPARENT) && unlocked && // R6
				(sess_open || (!rec_busy && state == ST_IDLE)); // R5
		end
	end

	////////////////////////////////////////////////////////////////////////
	// passive monitor with seconds timeout
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mon_open <= 1'b0;
			mon_spent <= 1'b0;
			mon_left <= '0;
			mon_tmr <= '0;
		end else if (role != ROLE_MONITOR) begin
			mon_open <= 1'b0;
			mon_spent <= 1'b0;
		end else if (!mon_open) begin
			if (!mon_spent && mon_timeout_s != '0) begin
				mon_open <= 1'b1; // R7
				mon_left <= mon_timeout_s;
				mon_tmr <= '0;
			end
		end else if (rx_valid) begin
			mon_left <= mon_timeout_s; // traffic restarts timeout
			mon_tmr <= '0;
		end else if (mon_tmr == SEC_LAST) begin
			mon_tmr <= '0;
			mon_left <= mon_left - 8'h01;
			if (mon_left == 8'h01) begin
				mon_open <= 1'b0; // R7
				mon_spent <= 1'b1;
			end
		end else begin
			mon_tmr <= mon_tmr + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// received traffic to the operator terminal
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			term_out <= '0;
		end else begin
			term_out.valid <= rx_valid && (sess_open || mon_open); // R4
			term_out.data <= (mon_open && !mon_ascii) ? rx_sh :
				{1'b0, rx_sh[6:0]}; // R7
		end
	end

endmodule

`default_nettype wire

// ===== rtl/sdi_pkg.sv
// shared constants, enums and carriers of the sdi-12 port
// assumes a 10 MHz system clock and one instance per port
package sdi_pkg;

	// line timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned BAUD = 1200;
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
	localparam int unsigned SEC_S = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_S;
	localparam int unsigned RESP_WAIT_MS = 100;
	localparam int unsigned RESP_CYCLES = CLK_HZ / 1000 * RESP_WAIT_MS;
	localparam int BAUD_W = 14;
	localparam int TMR_W = 24;
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [1:0] RETRIES = 2'h3;

	// characters (7-bit)
	localparam logic [6:0] CH_EXCL = 7'h21;
	localparam logic [6:0] CH_QUERY = 7'h3F;
	localparam logic [6:0] CH_CR = 7'h0D;
	localparam logic [6:0] CH_LF = 7'h0A;
	localparam logic [6:0] CH_ZERO = 7'h30;
	localparam logic [6:0] CH_NINE = 7'h39;
	localparam logic [6:0] CH_LA = 7'h61;
	localparam logic [6:0] CH_LZ = 7'h7A;
	localparam logic [6:0] CH_UA = 7'h41;
	localparam logic [6:0] CH_UZ = 7'h5A;
	localparam logic [6:0] CH_M = 7'h4D;
	localparam logic [6:0] CH_C = 7'h43;
	localparam logic [6:0] CH_R = 7'h52;
	localparam logic [6:0] CH_V = 7'h56;
	localparam logic [6:0] CH_I = 7'h49;
	localparam logic [6:0] CH_D = 7'h44;

	typedef enum logic [2:0] {
		ROLE_IDLE        = 3'h0,
		ROLE_RECORDER    = 3'h1,
		ROLE_SENSOR      = 3'h2,
		ROLE_TRANSPARENT = 3'h3,
		ROLE_MONITOR     = 3'h4
	} role_e;

	typedef enum logic [3:0] {
		SK_NONE  = 4'h0,
		SK_M     = 4'h1,
		SK_MC    = 4'h2,
		SK_C     = 4'h3,
		SK_CC    = 4'h4,
		SK_R     = 4'h5,
		SK_RC    = 4'h6,
		SK_V     = 4'h7,
		SK_QUERY = 4'h8,
		SK_I     = 4'h9
	} skind_e;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CMD   = 5'h02,
		ST_RESP  = 5'h04,
		ST_MWAIT = 5'h08,
		ST_REPLY = 5'h10
	} state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} char_s;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [6:0] data;
	} reply_s;

	typedef struct packed {
		logic       start;
		logic [6:0] addr;
	} rec_req_s;

	typedef struct packed {
		logic done;
		logic no_resp;
	} rec_res_s;

	typedef struct packed {
		logic       valid;
		skind_e     kind;
		logic [6:0] qual;
	} scmd_s;

	function automatic logic is_digit(input logic [6:0] c);
		return (c >= CH_ZERO) && (c <= CH_NINE);
	endfunction

	function automatic logic is_addr(input logic [6:0] c);
		return is_digit(c) || ((c >= CH_LA) && (c <= CH_LZ)) ||
			((c >= CH_UA) && (c <= CH_UZ));
	endfunction

endpackage

// ===== test/sdi12_port_monitor.sv
// checker of the sdi-12 port outputs against their causes
// assumes one clock domain and binding onto every sdi12_port
`timescale 1ns/10ps
`default_nettype none

module sdi12_port_monitor (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              nrst,
	// wire and setup
	input wire logic              sdi_out,
	input wire logic              sdi_oe,
	input wire sdi_pkg::role_e    role,
	input wire logic              unlocked,
	input wire logic              partner_locked,
	// recorder
	input wire sdi_pkg::rec_req_s rec_req,
	input wire logic              rec_busy,
	input wire sdi_pkg::char_s    rec_data,
	input wire sdi_pkg::rec_res_s rec_result,
	// sensor role and terminal
	input wire sdi_pkg::scmd_s    sensor_cmd,
	input wire logic              term_ready,
	input wire logic              sess_open,
	input wire logic [7:0]        mon_timeout_s,
	input wire logic              mon_open
);
	import sdi_pkg::*;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////
	// role, locking and sessions
	a_lock_role: assert property ((role != ROLE_IDLE) [*3] |-> partner_locked)
		else $error("partner pin not locked while port in use");
	a_unlock_idle: assert property ((role == ROLE_IDLE) [*3] |-> !partner_locked)
		else $error("partner pin locked while port idle");
	a_no_record: assert property ((role == ROLE_TRANSPARENT) [*2] |->
		!rec_data.valid && !rec_result.done)
		else $error("data recorded in transparent use");
	a_ready_session: assert property (term_ready |-> sess_open)
		else $error("terminal ready without open session");
	a_session_alone: assert property (sess_open |-> !rec_busy)
		else $error("session open during recorder sequence");
	a_session_unlock: assert property ($rose(sess_open) |->
		$past(unlocked) && $past(role) == ROLE_TRANSPARENT)
		else $error("session opened while locked");
	a_mon_passive: assert property (mon_open |-> !sdi_oe)
		else $error("monitor drives the wire");
	a_mon_zero: assert property ((mon_timeout_s == 8'h00) [*3] |-> !mon_open)
		else $error("monitor opened with zero timeout");

	////////////////////////////////////////////////////////////////////////
	// line, recorder and sensor role
	a_start_level: assert property ($rose(sdi_oe) |-> sdi_out [*8])
		else $error("start bit not held on the wire");
	a_bad_addr: assert property (rec_req.start && role == ROLE_RECORDER &&
		!rec_busy && !is_addr(rec_req.addr) |-> ##1 !rec_busy ##1 !rec_busy)
		else $error("recorder started on an illegal address");
	a_rec_start: assert property (rec_req.start && role == ROLE_RECORDER &&
		!rec_busy && is_addr(rec_req.addr) |-> ##[1:2] rec_busy)
		else $error("recorder did not start");
	a_result_free: assert property (rec_result.done |-> ##[0:2] !rec_busy)
		else $error("port still busy after result");
	a_cmd_kind: assert property (sensor_cmd.valid |-> role == ROLE_SENSOR &&
		sensor_cmd.kind inside {[SK_M:SK_I]})
		else $error("sensor command outside sensor role or list");

	c_rec_ok: cover property (rec_result.done && !rec_result.no_resp);
	c_rec_silent: cover property (rec_result.done && rec_result.no_resp);
	c_sensor: cover property (sensor_cmd.valid);
	c_session: cover property ($rose(sess_open));
	c_monitor: cover property ($rose(mon_open));
endmodule

bind sdi12_port sdi12_port_monitor mon (
	.clk_sys(clk_sys), .nrst(nrst), .sdi_out(sdi_out), .sdi_oe(sdi_oe),
	.role(role), .unlocked(unlocked), .partner_locked(partner_locked),
	.rec_req(rec_req), .rec_busy(rec_busy), .rec_data(rec_data),
	.rec_result(rec_result), .sensor_cmd(sensor_cmd),
	.term_ready(term_ready), .sess_open(sess_open),
	.mon_timeout_s(mon_timeout_s), .mon_open(mon_open)
);

`default_nettype wire

// ===== test/sdi_probe.sv
// behavioural probe at address 1 on the sdi-12 wire
// assumes the bench resolves the wire; released wire pulls to marking (0)
`timescale 1ns/10ps
`default_nettype none

module sdi_probe #(
	parameter int BIT = 16
) (
	// clock and wire
	input  wire logic  clk_sys,
	input  wire logic  line,
	output logic       p_out,
	output logic       p_oe,
	// behaviour and observation
	input  wire logic  silent,
	output logic [6:0] rx_char,
	output logic       rx_stb
);
	string cmd;

	// one frame: start, 7 bits lsb first, even parity, stop, inverted
	task automatic send_char(input logic [6:0] c);
		logic [9:0] f;
		f = {1'b1, ^c, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			#1;
			p_oe = 1'b1;
			p_out = ~f[i];
			repeat (BIT - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		#1;
		p_oe = 1'b0;
		p_out = 1'b0;
	endtask

	task automatic send_str(input string s);
		foreach (s[i]) send_char(s[i][6:0]);
	endtask

	// receive at mid bit, drop bad frames, answer own address only
	initial begin
		logic [8:0] b;
		p_oe = 1'b0;
		p_out = 1'b0;
		rx_stb = 1'b0;
		rx_char = 7'h00;
		cmd = "";
		forever begin
			@(posedge clk_sys);
			if (line && !p_oe) begin
				repeat (BIT / 2) @(posedge clk_sys);
				for (int i = 0; i < 9; i++) begin
					repeat (BIT) @(posedge clk_sys);
					b[i] = ~line;
				end
				if (!(^b[7:0]) && b[8]) begin
					#1 rx_char = b[6:0];
					rx_stb = 1'b1;
					@(posedge clk_sys);
					#1 rx_stb = 1'b0;
					cmd = $sformatf("%s%c", cmd, b[6:0]);
					if (b[6:0] == 7'h0A) cmd = "";
					if (b[6:0] == 7'h21) begin
						if (!silent && cmd[0] == "1") begin
							repeat (20) @(posedge clk_sys);
							if (cmd == "1M!") send_str("10011\015\012");
							else if (cmd == "1D0!") send_str("1+5\015\012");
							else send_str("1x\015\012");
						end
						cmd = "";
					end
				end
			end
		end
	end
endmodule

`default_nettype wire

// ===== test/test_sdi12_port.sv
// self-checking bench of one sdi-12 port with a probe on its wire
// assumes shortened bit, second and response counts
`timescale 1ns/10ps
`default_nettype none

module test_sdi12_port;
	import sdi_pkg::*;

	logic clk_sys = 1'b0, nrst = 1'b0;
	logic sdi_out, sdi_oe, p_out, p_oe, silent, rx_stb;
	logic [6:0] rx_char, sensor_addr;
	role_e role;
	logic unlocked, partner_locked, rec_busy, reply_ready;
	logic term_ready, sess_open, mon_ascii, mon_open;
	logic [7:0] mon_timeout_s;
	rec_req_s rec_req;
	char_s rec_data, term_in, term_out;
	rec_res_s rec_result;
	scmd_s sensor_cmd;
	reply_s reply_in;
	logic [15:0] exp_q[$];
	logic [31:0] lfsr = 32'hA0F2;
	int n_mismatch = 0, compares = 0, cyc = 0;
	wire line = sdi_oe ? sdi_out : (p_oe ? p_out : 1'b0);
	skind_e kinds[9] = '{SK_M, SK_MC, SK_C, SK_CC, SK_R, SK_RC, SK_V,
		SK_QUERY, SK_I};
	string cmds[9] = '{"3M!", "3MC!", "3C!", "3CC!", "3R0!", "3RC1!",
		"3V!", "?!", "3I!"};

	sdi12_port #(.BIT_CYC(16), .SEC_CYC(200), .RESP_CYC(400)) dut (
		.clk_sys(clk_sys), .nrst(nrst), .sdi_in(line), .sdi_out(sdi_out),
		.sdi_oe(sdi_oe), .role(role), .unlocked(unlocked),
		.sensor_addr(sensor_addr), .partner_locked(partner_locked),
		.rec_req(rec_req), .rec_busy(rec_busy), .rec_data(rec_data),
		.rec_result(rec_result), .sensor_cmd(sensor_cmd),
		.reply_in(reply_in), .reply_ready(reply_ready), .term_in(term_in),
		.term_ready(term_ready), .term_out(term_out), .sess_open(sess_open),
		.mon_timeout_s(mon_timeout_s), .mon_ascii(mon_ascii),
		.mon_open(mon_open));

	sdi_probe #(.BIT(16)) p (
		.clk_sys(clk_sys), .line(line), .p_out(p_out), .p_oe(p_oe),
		.silent(silent), .rx_char(rx_char), .rx_stb(rx_stb));

	always #50 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic tally_and_finish;
		check("pending events", 16'(exp_q.size()), 16'h0000);
		if (n_mismatch == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// expected probe receptions and terminal echoes
	task automatic note_rx(input string s);
		foreach (s[i]) exp_q.push_back({4'h5, 5'h00, s[i][6:0]});
	endtask

	task automatic note_term(input string s);
		foreach (s[i]) exp_q.push_back({8'h40, (role == ROLE_MONITOR &&
			!mon_ascii) & ^s[i][6:0], s[i][6:0]});
	endtask

	task automatic drain(input int n);
		for (int i = 0; i < n && exp_q.size() != 0; i++) tick(1);
		tick(20);
	endtask

	task automatic send_term(input string s);
		foreach (s[i]) begin
			term_in = {1'b1, s[i]};
			for (int w = 0; w < 5000 && term_ready !== 1'b1; w++) tick(1);
			tick(1);
			term_in = '0;
			tick(1);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// watcher: each result takes the oldest note
	always @(posedge clk_sys) begin
		logic [15:0] seen;
		#5;
		seen = 16'hFFFF;
		if (rec_data.valid) seen = {4'h1, 4'h0, rec_data.data};
		if (rec_result.done) seen = {4'h2, 11'h000, rec_result.no_resp};
		if (sensor_cmd.valid) seen = {4'h3, sensor_cmd.kind, 1'b0,
			sensor_cmd.qual};
		if (term_out.valid) seen = {4'h4, 4'h0, term_out.data};
		if (rx_stb) seen = {4'h5, 5'h00, rx_char};
		if (seen != 16'hFFFF)
			check("event", seen, exp_q.size() ? exp_q.pop_front() : 16'hEEEE);
	end

	// run ceiling
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			check("run length", 16'h0001, 16'h0000);
			tally_and_finish;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		role = ROLE_IDLE;
		unlocked = 1'b0;
		sensor_addr = 7'h33;
		rec_req = '0;
		reply_in = '0;
		term_in = '0;
		mon_timeout_s = 8'h00;
		mon_ascii = 1'b0;
		silent = 1'b0;
		tick(20);
		nrst = 1'b1;
		tick(2);
		check("idle", {partner_locked, rec_busy, sess_open, mon_open, sdi_oe,
			term_ready}, 16'h0000);
		// recorder: illegal address refused, then measure and fetch
		role = ROLE_RECORDER;
		tick(3);
		check("locked", partner_locked, 16'h0001);
		rec_req = {1'b1, 7'h20 | 7'(lfsr[3:0])};
		tick(1);
		rec_req = '0;
		tick(4);
		check("busy", rec_busy, 16'h0000);
		note_rx("1M!");
		note_rx("1D0!");
		exp_q.push_back(16'h102B);
		exp_q.push_back(16'h1035);
		exp_q.push_back(16'h2000);
		rec_req = {1'b1, 7'h31};
		tick(1);
		rec_req = '0;
		drain(6000);
		// silent probe: four tries then no-response result
		silent = 1'b1;
		repeat (4) note_rx("1M!");
		exp_q.push_back(16'h2001);
		rec_req = {1'b1, 7'h31};
		tick(1);
		rec_req = '0;
		drain(8000);
		silent = 1'b0;
		// sensor role: foreign address ignored, every command answered
		role = ROLE_SENSOR;
		tick(3);
		p.send_str("5M!");
		tick(200);
		reply_in.valid = 1'b1;
		reply_in.last = 1'b1;
		for (int k = 0; k < 9; k++) begin
			lfsr = next_rand(lfsr);
			reply_in.data = 7'h30 + 7'(lfsr[3:0] % 10);
			exp_q.push_back({4'h3, kinds[k], 1'b0,
				(k == 5) ? 7'h31 : 7'h30});
			note_rx("3");
			if (k != 7) exp_q.push_back({4'h5, 5'h00, reply_in.data});
			note_rx("\015\012");
			p.send_str(cmds[k]);
			drain(4000);
		end
		reply_in = '0;
		// transparent: locked first, then a full pass-through
		role = ROLE_TRANSPARENT;
		tick(5);
		check("session", sess_open, 16'h0000);
		unlocked = 1'b1;
		tick(5);
		check("session", sess_open, 16'h0001);
		note_rx("1I!");
		note_term("1x\015\012");
		send_term("1I!");
		drain(4000);
		// monitor: passive echo, closes after the quiet timeout
		role = ROLE_MONITOR;
		mon_timeout_s = 8'h01 + 8'(lfsr[4]);
		mon_ascii = lfsr[5];
		tick(5);
		check("monitor", mon_open, 16'h0001);
		note_term("0I!");
		p.send_str("0I!");
		drain(2000);
		tick(200 * mon_timeout_s + 100);
		check("monitor", mon_open, 16'h0000);
		tally_and_finish;
	end
endmodule

`default_nettype wire
